// ### verilog/cexfi_defs.svh
// Register offsets, field positions and reset values of the cell extremes and fault id registers
`ifndef CEXFI_DEFS_SVH
`define CEXFI_DEFS_SVH

`define CEXFI_ADDR_W 8
`define CEXFI_IDX_W 6
`define CEXFI_IDX_EXTREME 6'h0a
`define CEXFI_IDX_FAULT 6'h0b
`define CEXFI_IDX_SERIAL_LO 6'h0d
`define CEXFI_IDX_SERIAL_HI 6'h0e
`define CEXFI_BYTE_SEL 2'h0

`define CEXFI_CELLS 12
`define CEXFI_CELL_W 16
`define CEXFI_IDXF_W 4
`define CEXFI_IDX_RESET 4'hf
`define CEXFI_FIRST_CELL 4'h1

`define CEXFI_HIGH_LSB 8
`define CEXFI_LOW_LSB 0
`define CEXFI_HEADROOM_BIT 2
`define CEXFI_OVERVOLT_BIT 0
`define CEXFI_FAULT_RESET 16'h0000

`define CEXFI_SERIAL_W 24
`define CEXFI_SERIAL_SPLIT 16
`define CEXFI_ROM_LSB 8
`define CEXFI_BYTE_W 8
`define CEXFI_SERIAL_DEFAULT 24'h00a5c3

`define CEXFI_REG_W 16
`define CEXFI_DATA_W 32
`define CEXFI_ZERO_16 16'h0000

`endif

// ### verilog/cexfi_pkg.sv
// Types shared by the cell extremes and fault id register block
`include "cexfi_defs.svh"
package cexfi_pkg;
  typedef logic [`CEXFI_IDXF_W-1:0] cexfi_cell_num_type;
  typedef logic [`CEXFI_CELL_W-1:0] cexfi_result_type;
  typedef logic [`CEXFI_REG_W-1:0] cexfi_reg_type;
endpackage

// ### verilog/cexfi_sticky_flag.sv
// Sticky fault flag: set by hardware, cleared by writing zero, set wins over clear
`timescale 1ns/100ps
module cexfi_sticky_flag
  import cexfi_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic set_evt,
  input wire logic clear_req,
  output logic flag_r
);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_r <= 1'b0;
    end
    else if (set_evt)
    begin
      // An event in the clearing cycle must not be lost
      flag_r <= 1'b1;
    end
    else if (clear_req)
    begin
      flag_r <= 1'b0;
    end
  end

endmodule

// ### verilog/cexfi_extreme_finder.sv
// Combinational search for the highest and lowest cell result, ties to the highest cell number
`timescale 1ns/100ps
`include "cexfi_defs.svh"
module cexfi_extreme_finder
  import cexfi_pkg::*;
(
  input wire logic [`CEXFI_CELLS*`CEXFI_CELL_W-1:0] cell_results,
  output cexfi_cell_num_type high_num,
  output cexfi_cell_num_type low_num
);

  cexfi_result_type hi_val [`CEXFI_CELLS];
  cexfi_result_type lo_val [`CEXFI_CELLS];
  cexfi_cell_num_type hi_num [`CEXFI_CELLS];
  cexfi_cell_num_type lo_num [`CEXFI_CELLS];

  assign hi_val[0] = cell_results[`CEXFI_CELL_W-1:0];
  assign lo_val[0] = cell_results[`CEXFI_CELL_W-1:0];
  assign hi_num[0] = `CEXFI_FIRST_CELL;
  assign lo_num[0] = `CEXFI_FIRST_CELL;

  // Scanning upward with >= and <= lets a later equal cell take over
  genvar g;
  generate
    for (g = 1; g < `CEXFI_CELLS; g++)
    begin : g_scan
      cexfi_result_type v;
      assign v = cell_results[g*`CEXFI_CELL_W +: `CEXFI_CELL_W];
      assign hi_val[g] = (v >= hi_val[g-1]) ? v : hi_val[g-1];
      assign hi_num[g] = (v >= hi_val[g-1]) ? cexfi_cell_num_type'(g + 1) : hi_num[g-1];
      assign lo_val[g] = (v <= lo_val[g-1]) ? v : lo_val[g-1];
      assign lo_num[g] = (v <= lo_val[g-1]) ? cexfi_cell_num_type'(g + 1) : lo_num[g-1];
    end
  endgenerate

  assign high_num = hi_num[`CEXFI_CELLS-1];
  assign low_num = lo_num[`CEXFI_CELLS-1];

endmodule

// ### verilog/cexfi_regs.sv
// APB register block: extreme cell indices, sticky supply faults, serial code and ROM check
//
// Chosen here: the APB register port.
`timescale 1ns/100ps
`include "cexfi_defs.svh"
module cexfi_regs
  import cexfi_pkg::*;
#(
  // Arbitrary neutral value, replaced by the factory-programmed code
  parameter logic [`CEXFI_SERIAL_W-1:0] UNIT_SERIAL_CODE = `CEXFI_SERIAL_DEFAULT
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CEXFI_ADDR_W-1:0] paddr,
  input wire logic [`CEXFI_DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [`CEXFI_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`CEXFI_CELLS*`CEXFI_CELL_W-1:0] cell_results,
  input wire logic results_update,
  input wire logic headroom_low_evt,
  input wire logic overvoltage_evt,
  input wire logic alert_reset_flag,
  input wire logic [7:0] rom_check_value,
  output logic supply_headroom_alert,
  output logic supply_overvoltage_alert
);

  cexfi_cell_num_type highest_cell_index_r;
  cexfi_cell_num_type lowest_cell_index_r;
  cexfi_cell_num_type high_found;
  cexfi_cell_num_type low_found;
  cexfi_reg_type rdata_nxt;
  logic [`CEXFI_DATA_W-1:0] prdata_r;
  logic pslverr_r;
  logic setup;
  logic access;
  logic hit_extreme;
  logic hit_fault;
  logic hit_serial_lo;
  logic hit_serial_hi;
  logic mapped;
  logic fault_wr;
  logic clr_headroom;
  logic clr_overvolt;

  cexfi_extreme_finder u_finder
  (
    .cell_results(cell_results),
    .high_num(high_found),
    .low_num(low_found)
  );

  // Indices follow the stored results, never the bus
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      highest_cell_index_r <= `CEXFI_IDX_RESET;
      lowest_cell_index_r <= `CEXFI_IDX_RESET;
    end
    else if (results_update)
    begin
      highest_cell_index_r <= high_found;
      lowest_cell_index_r <= low_found;
    end
  end

  // Address decode: byte address is four times the register index
  assign hit_extreme = (paddr == {`CEXFI_IDX_EXTREME, `CEXFI_BYTE_SEL});
  assign hit_fault = (paddr == {`CEXFI_IDX_FAULT, `CEXFI_BYTE_SEL});
  assign hit_serial_lo = (paddr == {`CEXFI_IDX_SERIAL_LO, `CEXFI_BYTE_SEL});
  assign hit_serial_hi = (paddr == {`CEXFI_IDX_SERIAL_HI, `CEXFI_BYTE_SEL});
  assign mapped = hit_extreme | hit_fault | hit_serial_lo | hit_serial_hi;

  assign setup = psel & ~penable;
  assign access = psel & penable;

  // Only the fault register accepts writes, and only through byte lane 0
  assign fault_wr = access & pwrite & hit_fault & pstrb[0];
  assign clr_headroom = fault_wr & ~pwdata[`CEXFI_HEADROOM_BIT];
  assign clr_overvolt = fault_wr & ~pwdata[`CEXFI_OVERVOLT_BIT];

  cexfi_sticky_flag u_headroom
  (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(headroom_low_evt),
    .clear_req(clr_headroom),
    .flag_r(supply_headroom_alert)
  );

  cexfi_sticky_flag u_overvolt
  (
    .pclk(pclk),
    .presetn(presetn),
    .set_evt(overvoltage_evt & ~alert_reset_flag),
    .clear_req(clr_overvolt),
    .flag_r(supply_overvoltage_alert)
  );

  // Read mux builds every field explicitly so reserved bits stay zero
  always_comb
  begin
    rdata_nxt = `CEXFI_ZERO_16;
    if (hit_extreme)
    begin
      rdata_nxt[`CEXFI_HIGH_LSB +: `CEXFI_IDXF_W] = highest_cell_index_r;
      rdata_nxt[`CEXFI_LOW_LSB +: `CEXFI_IDXF_W] = lowest_cell_index_r;
    end
    else if (hit_fault)
    begin
      rdata_nxt[`CEXFI_HEADROOM_BIT] = supply_headroom_alert;
      rdata_nxt[`CEXFI_OVERVOLT_BIT] = supply_overvoltage_alert;
    end
    else if (hit_serial_lo)
    begin
      rdata_nxt = UNIT_SERIAL_CODE[`CEXFI_SERIAL_SPLIT-1:0];
    end
    else if (hit_serial_hi)
    begin
      rdata_nxt[`CEXFI_BYTE_W-1:0] = UNIT_SERIAL_CODE[`CEXFI_SERIAL_W-1:`CEXFI_SERIAL_SPLIT];
      rdata_nxt[`CEXFI_ROM_LSB +: `CEXFI_BYTE_W] = rom_check_value;
    end
  end

  // Read data is captured in the setup cycle so the slave answers with no wait state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= '0;
    end
    else if (setup)
    begin
      prdata_r <= pwrite ? '0 : {`CEXFI_ZERO_16, rdata_nxt};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_r <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_r <= ~mapped;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = pslverr_r & access;

endmodule

// ### sim/cexfi_regs_monitor.sv
// Checker of the cell extremes and fault id register block
`timescale 1ns/100ps
module cexfi_regs_monitor
  import cexfi_pkg::*;
#(
  // Arbitrary neutral value, overridden by the bind with the design's code
  parameter logic [23:0] UNIT_SERIAL_CODE = 24'h00a5c3
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic headroom_low_evt,
  input wire logic overvoltage_evt,
  input wire logic alert_reset_flag,
  input wire logic [7:0] rom_check_value,
  input wire logic supply_headroom_alert,
  input wire logic supply_overvoltage_alert
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic rd;
  logic wr;
  assign rd = psel && penable && !pwrite;
  assign wr = psel && penable && pwrite;
  property p_rsv; rd && paddr == 8'h28 |-> prdata[31:12] == 20'h0 && prdata[7:4] == 4'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_lo; rd && paddr == 8'h34 |-> prdata == {16'h0, UNIT_SERIAL_CODE[15:0]};
  endproperty
  a_lo: assert property (p_lo) else $error("serial low wrong");
  property p_hi; rd && paddr == 8'h38 |-> prdata == {16'h0, $past(rom_check_value), UNIT_SERIAL_CODE[23:16]};
  endproperty
  a_hi: assert property (p_hi) else $error("serial high wrong");
  property p_hdrm; headroom_low_evt |=> supply_headroom_alert;
  endproperty
  a_hdrm: assert property (p_hdrm) else $error("headroom not set");
  property p_ov; overvoltage_evt && !alert_reset_flag |=> supply_overvoltage_alert;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage not set");
  property p_gate; $rose(supply_overvoltage_alert) |-> $past(overvoltage_evt && !alert_reset_flag);
  endproperty
  a_gate: assert property (p_gate) else $error("overvoltage set without cause");
  property p_hold; supply_headroom_alert && !(wr && paddr == 8'h2c && pstrb[0] && !pwdata[2]) |=> supply_headroom_alert;
  endproperty
  a_hold: assert property (p_hold) else $error("headroom lost");
  property p_ro; wr && paddr != 8'h2c && !headroom_low_evt && !overvoltage_evt
    |=> $stable(supply_headroom_alert) && $stable(supply_overvoltage_alert);
  endproperty
  a_ro: assert property (p_ro) else $error("flags moved on other write");
endmodule

bind cexfi_regs cexfi_regs_monitor #(.UNIT_SERIAL_CODE(UNIT_SERIAL_CODE)) u_mon (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .headroom_low_evt, .overvoltage_evt, .alert_reset_flag,
  .rom_check_value, .supply_headroom_alert, .supply_overvoltage_alert);

// ### sim/test_cell_extremes_fault_id_regs.sv
// Testbench of the cell extremes and fault id register block
`timescale 1ns/100ps
module test_cell_extremes_fault_id_regs;
  localparam logic [23:0] SER = 24'h3c5a96; // Arbitrary serial code
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, upd = 0, hdrm = 0, ovv = 0, arst = 1;
  logic [7:0] paddr = 0, rom = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0] pstrb = 0;
  logic [191:0] cells = 0;
  logic pready, pslverr, err, ha, oa;
  int mismatches = 0, check_count = 0, cyc = 0, v[12], hi, lo, mx, mn;
  always #2.5 pclk = ~pclk;
  cexfi_regs #(.UNIT_SERIAL_CODE(SER)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cell_results(cells), .results_update(upd), .headroom_low_evt(hdrm),
    .overvoltage_evt(ovv), .alert_reset_flag(arst), .rom_check_value(rom), .supply_headroom_alert(ha),
    .supply_overvoltage_alert(oa));
  task automatic chk(input string n, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Called right after a rising edge; ends one idle edge later so psel is never assigned twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic ev(input logic h, o);
    hdrm <= h;
    ovv <= o;
    @(posedge pclk);
    hdrm <= 0;
    ovv <= 0;
    @(posedge pclk);
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial
  begin
    void'($urandom(27498));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 8'h28, 0, 0);
    chk("extremes", rd, 32'h0f0f);
    chk("alerts", {30'h0, ha, oa}, 32'h0);
    repeat (6)
    begin
      mx = -1;
      mn = 99;
      // Narrow range forces ties
      for (int i = 0; i < 12; i++)
      begin
        v[i] = $urandom % 4;
        cells[i*16 +: 16] <= v[i][15:0];
        hi = (v[i] >= mx) ? i + 1 : hi;
        mx = (v[i] >= mx) ? v[i] : mx;
        lo = (v[i] <= mn) ? i + 1 : lo;
        mn = (v[i] <= mn) ? v[i] : mn;
      end
      upd <= 1;
      @(posedge pclk);
      upd <= 0;
      apb(1, 8'h28, 32'hffffffff, 4'hf);
      apb(0, 8'h28, 0, 0);
      chk("extremes", rd, {20'h0, hi[3:0], 4'h0, lo[3:0]});
    end
    $display("extremes test done");
    rom <= 8'($urandom);
    apb(1, 8'h34, 32'hffffffff, 4'hf);
    apb(0, 8'h34, 0, 0);
    chk("serial low", rd, {16'h0, SER[15:0]});
    hi = rd[15:0];
    apb(0, 8'h38, 0, 0);
    chk("serial high", rd, {16'h0, rom, SER[23:16]});
    chk("serial ones", $countones({rd[7:0], hi[15:0]}) > 1, 1);
    $display("serial test done");
    ev(1, 0);
    apb(1, 8'h2c, 32'hffffffff, 4'hf);
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h4);
    ev(0, 1);
    arst <= 0;
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h4);
    ev(0, 1);
    apb(1, 8'h2c, 0, 4'h0);
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h5);
    // Zeros written to a read-only register must not reach the flags
    apb(1, 8'h38, 0, 4'hf);
    chk("alerts", {30'h0, ha, oa}, 32'h3);
    apb(1, 8'h2c, 32'h1, 4'h1);
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h1);
    apb(1, 8'h2c, 0, 4'h1);
    apb(0, 8'h30, 0, 0);
    chk("unmapped", {rd[30:0], err}, 1);
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h0);
    // Event only in the access cycle of a clearing write: the set must win
    fork
      apb(1, 8'h2c, 0, 4'h1);
      begin
        @(posedge pclk);
        hdrm <= 1;
        @(posedge pclk);
        hdrm <= 0;
      end
    join
    chk("alerts", {30'h0, ha, oa}, 32'h2);
    apb(0, 8'h2c, 0, 0);
    chk("faults", rd, 32'h4);
    $display("fault test done");
    tally_and_finish();
  end
endmodule
